// [verilog/hbr_cfg.svh]
// Purpose: constants of the host buffer RAM access port
// Assumes: byte-organised buffer RAM of 4096 bytes, 16-bit micro data port
// Notes:   included by the port module only
//
// What this block does
// - read-only 16-bit count of bytes waiting in isochronous buffer zero
// - read-only 16-bit count of bytes waiting in isochronous buffer one
// - isochronous port: even-address byte high, odd-address byte low
// - acknowledged port: odd-address byte high, even-address byte low
// - isochronous port commands 40h read, c0h write, issued once
// - acknowledged port commands 41h read, c1h write, issued once
// - buffer pointer advances two bytes per data word
// - reaching byte count raises end of transfer and updates status
// - counter holds bytes, each port access moves one word; an odd-count final write stores only the even-address byte
// - status shows per-buffer full bits 0..2 and done bits 3..5
`ifndef HBR_CFG_SVH
`define HBR_CFG_SVH

// ************************************************************
// command codes
// ************************************************************
`define HBR_CMD_RD_LEN0  8'h2d
`define HBR_CMD_RD_LEN1  8'h2e
`define HBR_CMD_RD_ISO   8'h40
`define HBR_CMD_WR_ISO   8'hc0
`define HBR_CMD_RD_ACK   8'h41
`define HBR_CMD_WR_ACK   8'hc1

// ************************************************************
// layout, fields, reset values
// ************************************************************
`define HBR_RAM_BYTES    4096
`define HBR_BASE_ISO0    12'h000
`define HBR_BASE_ISO1    12'h400
`define HBR_BASE_ACK     12'h800
`define HBR_WORD_STEP    16'h0002
`define HBR_ST_DONE_LSB  3
`define HBR_LEN_RESET    16'h0000
`define HBR_ST_RESET     6'h00

`endif

// [verilog/hbr_pkg.sv]
// Purpose: types of the host buffer RAM access port
// Assumes: nothing
// Notes:   buffer select codes match status bit order
package hbr_pkg;

    typedef enum logic [2:0]
    {
        hbr_idle   = 3'b000,
        hbr_rd_iso = 3'b001,
        hbr_wr_iso = 3'b010,
        hbr_rd_ack = 3'b011,
        hbr_wr_ack = 3'b100
    } hbr_mode_t;

    typedef enum logic [1:0]
    {
        hbr_sel_iso0 = 2'b00,
        hbr_sel_iso1 = 2'b01,
        hbr_sel_ack  = 2'b10
    } hbr_sel_t;

    typedef struct packed
    {
        hbr_mode_t   mode;
        hbr_sel_t    sel;
        logic [15:0] ptr;
        logic [15:0] len0;
        logic [15:0] len1;
        logic [15:0] head;
        logic [15:0] tail;
        logic        head_v;
        logic        tail_v;
        logic [5:0]  status;
        logic        transfer_end_event;
    } hbr_state_t;

endpackage

// [verilog/hbr_port.sv]
// Purpose: micro-side command/data port into the shared host buffer RAM
// Assumes: one strobe per cycle at most; command strobe has priority
// Notes:   read data leaves through a two-entry buffer drained by rd_ready_in
`timescale 1ns/1ps
`include "hbr_cfg.svh"

module hbr_port
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        cmd_wr_in,
    input  wire logic [7:0]  cmd_in,
    input  wire logic        data_wr_in,
    input  wire logic [15:0] data_in,
    input  wire logic        rd_ready_in,
    input  wire logic        iso_sel_in,
    input  wire logic [15:0] transfer_byte_counter_in,
    input  wire logic [15:0] iso0_pending_bytes_in,
    input  wire logic [15:0] iso1_pending_bytes_in,
    input  wire logic [2:0]  hc_filled_in,
    input  wire logic [2:0]  hc_read_in,
    output logic             rd_valid_out,
    output logic [15:0]      rd_data_out,
    output logic [5:0]       buffer_status_out,
    output logic             all_transfer_end_flag_out
);

    // ************************************************************
    // storage and helpers
    // ************************************************************
    logic [7:0]         mem [0:`HBR_RAM_BYTES-1];
    hbr_pkg::hbr_state_t r_reg;
    hbr_pkg::hbr_state_t r_next;
    logic [11:0]        addr;
    logic [16:0]        step17;
    logic               live;
    logic               last;
    logic               odd_ok;
    logic               is_ack;
    logic               rd_mode;
    logic               wr_mode;
    logic               wr_en;
    logic [15:0]        wr_eo;
    logic [15:0]        rd_word;

    // swapping is its own inverse, so one function serves both directions
    function automatic logic [15:0] to_even_odd(input logic ack, input logic [15:0] w);
        to_even_odd = ack ? {w[7:0], w[15:8]} : w;
    endfunction

    function automatic logic [11:0] base_of(input hbr_pkg::hbr_sel_t s);
        case (s)
            hbr_pkg::hbr_sel_iso0: base_of = `HBR_BASE_ISO0;
            hbr_pkg::hbr_sel_iso1: base_of = `HBR_BASE_ISO1;
            default:               base_of = `HBR_BASE_ACK;
        endcase
    endfunction

    assign addr    = base_of(r_reg.sel) + r_reg.ptr[11:0];
    assign step17  = {1'b0, r_reg.ptr} + {1'b0, `HBR_WORD_STEP};
    assign live    = r_reg.ptr < transfer_byte_counter_in;
    assign last    = step17 >= {1'b0, transfer_byte_counter_in};
    assign odd_ok  = ({1'b0, r_reg.ptr} + 17'h00001) < {1'b0, transfer_byte_counter_in};
    assign is_ack  = (r_reg.sel == hbr_pkg::hbr_sel_ack);
    assign rd_mode = (r_reg.mode == hbr_pkg::hbr_rd_iso) || (r_reg.mode == hbr_pkg::hbr_rd_ack);
    assign wr_mode = (r_reg.mode == hbr_pkg::hbr_wr_iso) || (r_reg.mode == hbr_pkg::hbr_wr_ack);
    assign wr_eo   = to_even_odd(is_ack, data_in);
    assign rd_word = to_even_odd(is_ack, {mem[addr], mem[addr + 12'h001]});

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        r_next      = r_reg;
        r_next.transfer_end_event  = 1'b0;
        wr_en       = 1'b0;
        r_next.len0 = iso0_pending_bytes_in;
        r_next.len1 = iso1_pending_bytes_in;
        if (rd_ready_in && r_reg.head_v)
        begin
            r_next.head   = r_reg.tail;
            r_next.head_v = r_reg.tail_v;
            r_next.tail_v = 1'b0;
        end
        if (cmd_wr_in)
        begin
            // a new command abandons any unread prefetch
            r_next.ptr    = 16'h0000;
            r_next.mode   = hbr_pkg::hbr_idle;
            r_next.head_v = 1'b0;
            r_next.tail_v = 1'b0;
            case (cmd_in)
                `HBR_CMD_RD_LEN0:
                begin
                    r_next.head   = r_reg.len0;
                    r_next.head_v = 1'b1;
                end
                `HBR_CMD_RD_LEN1:
                begin
                    r_next.head   = r_reg.len1;
                    r_next.head_v = 1'b1;
                end
                `HBR_CMD_RD_ISO:
                begin
                    r_next.mode = hbr_pkg::hbr_rd_iso;
                    r_next.sel  = hbr_pkg::hbr_sel_t'({1'b0, iso_sel_in});
                end
                `HBR_CMD_WR_ISO:
                begin
                    r_next.mode = hbr_pkg::hbr_wr_iso;
                    r_next.sel  = hbr_pkg::hbr_sel_t'({1'b0, iso_sel_in});
                end
                `HBR_CMD_RD_ACK:
                begin
                    r_next.mode = hbr_pkg::hbr_rd_ack;
                    r_next.sel  = hbr_pkg::hbr_sel_ack;
                end
                `HBR_CMD_WR_ACK:
                begin
                    r_next.mode = hbr_pkg::hbr_wr_ack;
                    r_next.sel  = hbr_pkg::hbr_sel_ack;
                end
                default:
                begin
                end
            endcase
        end
        else if (wr_mode && live && data_wr_in)
        begin
            wr_en      = 1'b1;
            r_next.ptr = step17[15:0];
            r_next.transfer_end_event = last;
        end
        else if (rd_mode && live && !r_next.tail_v)
        begin
            // prefetch stalls while both entries hold unread words
            if (!r_next.head_v)
            begin
                r_next.head   = rd_word;
                r_next.head_v = 1'b1;
            end
            else
            begin
                r_next.tail   = rd_word;
                r_next.tail_v = 1'b1;
            end
            r_next.ptr = step17[15:0];
            r_next.transfer_end_event = last;
        end
        if (r_next.transfer_end_event)
        begin
            if (wr_mode)
            begin
                r_next.status[r_reg.sel] = 1'b1;
                r_next.status[`HBR_ST_DONE_LSB + r_reg.sel] = 1'b0;
            end
            else
            begin
                r_next.status[r_reg.sel] = 1'b0;
            end
        end
        // controller events applied last so they override a same-cycle transfer-end update
        r_next.status[2:0] = (r_next.status[2:0] & ~hc_read_in) | hc_filled_in;
        r_next.status[5:3] = r_next.status[5:3] | hc_read_in;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r_reg        <= '0;
            r_reg.mode   <= hbr_pkg::hbr_idle;
            r_reg.len0   <= `HBR_LEN_RESET;
            r_reg.len1   <= `HBR_LEN_RESET;
            r_reg.status <= `HBR_ST_RESET;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // buffer RAM has no reset, as a software reset must keep its contents
    always_ff @(posedge ref_clk_in)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_eo[15:8];
            if (odd_ok)
            begin
                mem[addr + 12'h001] <= wr_eo[7:0];
            end
        end
    end

    assign rd_valid_out              = r_reg.head_v;
    assign rd_data_out               = r_reg.head;
    assign buffer_status_out         = r_reg.status;
    assign all_transfer_end_flag_out = r_reg.transfer_end_event;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_len0_read;
        cmd_wr_in && cmd_in == `HBR_CMD_RD_LEN0
            |=> rd_valid_out && rd_data_out == $past(r_reg.len0);
    endproperty
    a_len0_read: assert property (p_len0_read) else $error("len0 read wrong");

    property p_len1_track;
        ##1 1'b1 |-> r_reg.len1 == $past(iso1_pending_bytes_in);
    endproperty
    a_len1_track: assert property (p_len1_track) else $error("len1 stale");

    property p_iso_order;
        wr_en && !is_ack |=> mem[$past(addr)] == $past(data_in[15:8]);
    endproperty
    a_iso_order: assert property (p_iso_order) else $error("iso byte order");

    property p_ack_order;
        wr_en && is_ack |=> mem[$past(addr)] == $past(data_in[7:0]);
    endproperty
    a_ack_order: assert property (p_ack_order) else $error("ack byte order");

    property p_cmd_iso;
        cmd_wr_in && cmd_in == `HBR_CMD_WR_ISO
            |=> r_reg.mode == hbr_pkg::hbr_wr_iso && r_reg.ptr == 16'h0000;
    endproperty
    a_cmd_iso: assert property (p_cmd_iso) else $error("iso write cmd");

    property p_cmd_ack;
        cmd_wr_in && cmd_in == `HBR_CMD_RD_ACK |=> r_reg.mode == hbr_pkg::hbr_rd_ack;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("ack read cmd");

    property p_step;
        wr_en |=> r_reg.ptr == $past(r_reg.ptr) + `HBR_WORD_STEP;
    endproperty
    a_step: assert property (p_step) else $error("pointer step");

    property p_eot_at_count;
        wr_en
            |=> all_transfer_end_flag_out
                == ($past(step17) >= {1'b0, $past(transfer_byte_counter_in)});
    endproperty
    a_eot_at_count: assert property (p_eot_at_count) else $error("eot timing");

    property p_no_overrun;
        wr_mode && !live && !cmd_wr_in |=> $stable(r_reg.ptr) && !all_transfer_end_flag_out;
    endproperty
    a_no_overrun: assert property (p_no_overrun) else $error("overrun");

    property p_done_set;
        hc_read_in[0] |=> buffer_status_out[`HBR_ST_DONE_LSB] && !buffer_status_out[0];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done bit");

endmodule

// [bench/hbr_micro_model.sv]
// Purpose: microprocessor side of the buffer port, as the host driver uses it
// Assumes: inputs of the port are driven at the falling edge
// Notes:   read words land in got; ready stalls at random
`timescale 1ns/1ps

module hbr_micro_model
(
    input  wire logic        ref_clk_in,
    input  wire logic        rd_valid_in,
    input  wire logic [15:0] rd_data_in,
    output logic             cmd_wr_out,
    output logic [7:0]       cmd_out,
    output logic             data_wr_out,
    output logic [15:0]      data_out,
    output logic             rd_ready_out,
    output logic             iso_sel_out,
    output logic [15:0]      count_out
);
    integer      seed;
    logic [15:0] got[$];

    initial
    begin
        seed         = 32'h01c7;
        cmd_wr_out   = 1'b0;
        cmd_out      = 8'h00;
        data_wr_out  = 1'b0;
        data_out     = 16'h0000;
        rd_ready_out = 1'b0;
        iso_sel_out  = 1'b0;
        count_out    = 16'h0000;
    end

    // ************************************************************
    // command, then words
    // ************************************************************
    // counts handed in stay inside each buffer's partition
    task automatic issue(input logic [7:0] code, input logic sel, input logic [15:0] n);
        @(negedge ref_clk_in);
        count_out   = n;
        iso_sel_out = sel;
        cmd_out     = code;
        cmd_wr_out  = 1'b1;
        @(negedge ref_clk_in);
        cmd_wr_out  = 1'b0;
    endtask

    task automatic write_words(input logic [15:0] w[$]);
        foreach (w[i])
        begin
            @(negedge ref_clk_in);
            data_wr_out = 1'b1;
            data_out    = w[i];
        end
        @(negedge ref_clk_in);
        data_wr_out = 1'b0;
        // released bus must not keep the last word
        data_out    = ~data_out;
    endtask

    // first cycles stall so the two-entry buffer fills up
    task automatic pop(input int n);
        int k;
        k = 0;
        got.delete();
        while (got.size() < n && k < 400)
        begin
            rd_ready_out = (k > 5) && ($random(seed) & 1);
            // outputs only move at the rising edge, so this is what that edge pops
            if (rd_valid_in === 1'b1 && rd_ready_out)
                got.push_back(rd_data_in);
            @(negedge ref_clk_in);
            k++;
        end
        rd_ready_out = 1'b0;
    endtask
endmodule

// [bench/host_buffer_ram_access_port_test.sv]
// Purpose: self-checking bench of the host buffer RAM access port
// Assumes: byte model of the RAM partitions at 000h, 400h, 800h
// Notes:   random data words, fixed seed
`timescale 1ns/1ps

module host_buffer_ram_access_port_test;
    logic        ref_clk_in;
    logic        rst_in;
    logic        cmd_wr, data_wr, rd_ready, iso_sel, rd_valid, transfer_end_event;
    logic [7:0]  cmd;
    logic [15:0] data, count, rd_data;
    logic [15:0] pend [0:1];
    logic [2:0]  hc_filled, hc_read;
    logic [5:0]  status, st_exp;
    logic [7:0]  mem [0:4095];
    integer      n_mismatch, samples_checked, seed;
    integer      n_eot = 0;

    hbr_port i_hbr_port (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_wr_in(cmd_wr),
        .cmd_in(cmd), .data_wr_in(data_wr), .data_in(data), .rd_ready_in(rd_ready),
        .iso_sel_in(iso_sel), .transfer_byte_counter_in(count),
        .iso0_pending_bytes_in(pend[0]), .iso1_pending_bytes_in(pend[1]),
        .hc_filled_in(hc_filled), .hc_read_in(hc_read), .rd_valid_out(rd_valid),
        .rd_data_out(rd_data), .buffer_status_out(status),
        .all_transfer_end_flag_out(transfer_end_event));

    hbr_micro_model i_hbr_micro_model (.ref_clk_in(ref_clk_in), .rd_valid_in(rd_valid),
        .rd_data_in(rd_data), .cmd_wr_out(cmd_wr), .cmd_out(cmd), .data_wr_out(data_wr),
        .data_out(data), .rd_ready_out(rd_ready), .iso_sel_out(iso_sel), .count_out(count));

    // one-cycle pulse, counted mid-cycle where it is settled
    always @(negedge ref_clk_in)
        if (transfer_end_event === 1'b1)
            n_eot <= n_eot + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic read_len(input logic sel, input logic [15:0] v);
        pend[sel] = v;
        i_hbr_micro_model.issue(sel ? 8'h2e : 8'h2d, 1'b0, 16'h0000);
        i_hbr_micro_model.pop(1);
        check(i_hbr_micro_model.got.size(), 1);
        check(i_hbr_micro_model.got[0], v);
    endtask

    // ************************************************************
    // one transfer against the byte model
    // ************************************************************
    task automatic xfer(input logic [7:0] code, input logic sel, input int n);
        int          base, nw, e0, b;
        logic [15:0] w[$];
        logic [15:0] word;
        logic [7:0]  ev, od;
        b    = code[0] ? 2 : sel;
        base = b * 'h400;
        nw   = (n + 1) / 2;
        e0   = n_eot;
        if (code == 8'h40)
            read_len(sel, n[15:0]);
        i_hbr_micro_model.issue(code, sel, n[15:0]);
        if (code[7])
        begin
            for (int i = 0; i < nw; i++)
                w.push_back($random(seed));
            i_hbr_micro_model.write_words(w[0:nw-2]);
            check(n_eot - e0, 0);
            i_hbr_micro_model.write_words(w[nw-1:nw-1]);
        end
        else
        begin
            i_hbr_micro_model.pop(nw);
            w = i_hbr_micro_model.got;
            check(w.size(), nw);
        end
        repeat (4) @(negedge ref_clk_in);
        check(rd_valid, 1'b0);
        check(n_eot - e0, 1);
        st_exp[b] = code[7];
        if (code[7])
            st_exp[b+3] = 1'b0;
        check(status, st_exp);
        for (int i = 0; i < nw && i < w.size(); i++)
        begin
            word = w[i];
            ev   = code[0] ? word[7:0] : word[15:8];
            od   = code[0] ? word[15:8] : word[7:0];
            if (code[7])
            begin
                mem[base+2*i] = ev;
                if (2 * i + 1 < n)
                    mem[base+2*i+1] = od;
            end
            else
            begin
                check(ev, mem[base+2*i]);
                if (2 * i + 1 < n)
                    check(od, mem[base+2*i+1]);
            end
        end
    endtask

    initial
    begin
        ref_clk_in = 1'b0;
        forever
            #20 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        seed            = 32'h01c7;
        n_mismatch      = 0;
        samples_checked = 0;
        rst_in          = 1'b1;
        pend[0]         = 16'h0000;
        pend[1]         = 16'h0000;
        hc_filled       = 3'h0;
        hc_read         = 3'h0;
        st_exp          = 6'h00;
        repeat (16) @(negedge ref_clk_in);
        rst_in = 1'b0;
        check({rd_valid, transfer_end_event, status}, 8'h00);
        read_len(1'b0, $random(seed));
        read_len(1'b1, $random(seed));
        xfer(8'hc0, 1'b0, 6);
        xfer(8'hc0, 1'b0, 5);
        xfer(8'h40, 1'b0, 6);
        xfer(8'hc0, 1'b1, 4);
        xfer(8'h40, 1'b1, 4);
        xfer(8'hc1, 1'b0, 8);
        xfer(8'hc1, 1'b0, 7);
        xfer(8'h41, 1'b0, 8);
        hc_read = 3'h7;
        @(negedge ref_clk_in);
        hc_read   = 3'h0;
        hc_filled = 3'h5;
        @(negedge ref_clk_in);
        hc_filled = 3'h0;
        @(negedge ref_clk_in);
        check(status, 6'h3d);
        finish_test();
    end
endmodule
